// >>> shared/fos_pkg.sv
// Purpose: constants for the fault reaction supervision block
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes:   no software-visible registers
//
// Contract
// - The supervisor sees each failure indication in the same cycle as the collection unit; the code skips indications of sources already pending.
// - For each enabled source the supervisor watches the unit's irq, non-maskable irq, reset and fault pins.
// - If no watched output reacts within the fixed interval the supervisor requests reset.
// - The supervisor needs no software configuration; its timing is fixed in hardware.
// - The chip periodically kicks the external watchdog, which takes each kick as a refresh.
// - The watchdog trigger may be a toggling pin or a message, per application.
// - The collection unit reacts per source with irq, non-maskable irq, reset, pins or none.
// - After software clears a failure the fault pins hold the failure state a minimum time.
package fos_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ          = 20000000;
    localparam int REACT_NS        = 1000;
    localparam int REACT_CYCLES    = (REACT_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int HOLD_US         = 100;
    localparam int HOLD_CYCLES     = HOLD_US * (CLK_HZ / 1000000);
    localparam int KICK_US         = 1000;
    localparam int KICK_CYCLES     = KICK_US * (CLK_HZ / 1000000);
    // ****************************************************************
    // reaction codes per source
    // ****************************************************************
    localparam logic [2:0] REACT_NONE = 3'h0;
    localparam logic [2:0] REACT_IRQ  = 3'h1;
    localparam logic [2:0] REACT_NMI  = 3'h2;
    localparam logic [2:0] REACT_RST  = 3'h3;
    localparam logic [2:0] REACT_PIN  = 3'h4;
    localparam int         REACT_W    = 3;
    localparam int         NSRC       = 8;
    // ****************************************************************
    // supervisor states
    // ****************************************************************
    typedef enum logic [2:0] {
        SV_IDLE  = 3'b001,
        SV_WATCH = 3'b010,
        SV_FAIL  = 3'b100
    } fos_sv_type;
endpackage

// >>> rtl/fos_supervision.sv
// Purpose: fault collection reaction plus its independent output supervisor
// Assumes: inputs synchronous to clk; reaction table is fixed by the integrator
// Notes:   watchdog kick toggles a pin at a fixed period
`timescale 1ns/1ps
module fos_supervision #(
    parameter int                                  NSRC         = fos_pkg::NSRC,
    parameter int                                  REACT_CYCLES = fos_pkg::REACT_CYCLES,
    parameter int                                  HOLD_CYCLES  = fos_pkg::HOLD_CYCLES,
    parameter int                                  KICK_CYCLES  = fos_pkg::KICK_CYCLES,
    parameter logic [NSRC*fos_pkg::REACT_W-1:0]    REACT_MAP    = {NSRC{fos_pkg::REACT_PIN}}
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            clk_en,
    // failure sources
    input  wire logic [NSRC-1:0] fault_in,
    input  wire logic            fault_clear,
    // collection unit reactions
    output logic                 fault_irq,
    output logic                 fault_nmi,
    output logic                 fault_reset_req,
    output logic [1:0]           fault_indication_pins,
    // supervisor and external watchdog
    output logic                 sup_reset_req,
    output logic                 wdog_kick
);
    localparam int CW = $clog2(HOLD_CYCLES + REACT_CYCLES + KICK_CYCLES + 2);

    function automatic logic [fos_pkg::REACT_W-1:0] react_of(input int i);
        react_of = REACT_MAP[i*fos_pkg::REACT_W +: fos_pkg::REACT_W];
    endfunction

    // ****************************************************************
    // collection unit
    // ****************************************************************
    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] next_pending;
    logic [NSRC-1:0] en_mask;
    logic [NSRC-1:0] new_fault;
    logic            want_irq;
    logic            want_nmi;
    logic            want_rst;
    logic            want_pin;
    logic [CW-1:0]   hold_cnt;
    logic [CW-1:0]   next_hold_cnt;
    logic            next_irq;
    logic            next_nmi;
    logic            next_rreq;
    logic            next_pin;

    for (genvar g = 0; g < NSRC; g++) begin : g_src
        assign en_mask[g] = (react_of(g) != fos_pkg::REACT_NONE);
    end

    assign new_fault = fault_in & ~pending & en_mask;

    always_comb begin
        want_irq = 1'b0;
        want_nmi = 1'b0;
        want_rst = 1'b0;
        want_pin = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (pending[i]) begin
                want_irq = want_irq | (react_of(i) == fos_pkg::REACT_IRQ);
                want_nmi = want_nmi | (react_of(i) == fos_pkg::REACT_NMI);
                want_rst = want_rst | (react_of(i) == fos_pkg::REACT_RST);
                want_pin = want_pin | (react_of(i) == fos_pkg::REACT_PIN);
            end
        end
        // set wins over clear
        next_pending = (fault_clear ? '0 : pending) | (fault_in & en_mask);
        next_irq  = want_irq;
        next_nmi  = want_nmi;
        next_rreq = want_rst;
        next_hold_cnt = hold_cnt;
        next_pin = fault_indication_pins[0];
        if (want_pin) begin
            next_pin = 1'b1;
            next_hold_cnt = CW'(HOLD_CYCLES);
        end else if (hold_cnt != '0) begin
            next_hold_cnt = hold_cnt - 1'b1;
        end else begin
            next_pin = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pending               <= '0;
            hold_cnt              <= '0;
            fault_irq             <= 1'b0;
            fault_nmi             <= 1'b0;
            fault_reset_req       <= 1'b0;
            fault_indication_pins <= 2'h0;
        end else if (clk_en) begin
            pending               <= next_pending;
            hold_cnt              <= next_hold_cnt;
            fault_irq             <= next_irq;
            fault_nmi             <= next_nmi;
            fault_reset_req       <= next_rreq;
            fault_indication_pins <= {~next_pin, next_pin};
        end
    end

    // ****************************************************************
    // output supervisor, fixed in hardware
    // ****************************************************************
    fos_pkg::fos_sv_type sv;
    fos_pkg::fos_sv_type next_sv;
    logic [CW-1:0]       sv_cnt;
    logic [CW-1:0]       next_sv_cnt;
    logic                reacted;
    logic                next_sup;

    // the supervisor taps fault_in through new_fault, masked by pending and en_mask, same cycle as the collection unit
    assign reacted = fault_irq | fault_nmi | fault_reset_req | fault_indication_pins[0];

    always_comb begin
        next_sv     = sv;
        next_sv_cnt = sv_cnt;
        next_sup    = sup_reset_req;
        case (sv)
            fos_pkg::SV_IDLE: begin
                if (|new_fault) begin
                    next_sv     = fos_pkg::SV_WATCH;
                    next_sv_cnt = CW'(REACT_CYCLES);
                end
            end
            fos_pkg::SV_WATCH: begin
                if (|new_fault) begin
                    next_sv_cnt = CW'(REACT_CYCLES);
                end else if (reacted) begin
                    next_sv = fos_pkg::SV_IDLE;
                end else if (sv_cnt == CW'(1)) begin
                    next_sv  = fos_pkg::SV_FAIL;
                    next_sup = 1'b1;
                end else begin
                    next_sv_cnt = sv_cnt - 1'b1;
                end
            end
            fos_pkg::SV_FAIL: begin
                next_sup = 1'b1;
            end
            default: begin
                next_sv = fos_pkg::SV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sv            <= fos_pkg::SV_IDLE;
            sv_cnt        <= '0;
            sup_reset_req <= 1'b0;
        end else if (clk_en) begin
            sv            <= next_sv;
            sv_cnt        <= next_sv_cnt;
            sup_reset_req <= next_sup;
        end
    end

    // ****************************************************************
    // external watchdog service
    // ****************************************************************
    logic [CW-1:0] kick_cnt;
    logic [CW-1:0] next_kick_cnt;
    logic          next_kick;

    always_comb begin
        next_kick     = wdog_kick;
        next_kick_cnt = kick_cnt - 1'b1;
        if (kick_cnt == '0) begin
            next_kick     = ~wdog_kick;
            next_kick_cnt = CW'(KICK_CYCLES - 1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            kick_cnt  <= '0;
            wdog_kick <= 1'b0;
        end else if (clk_en) begin
            kick_cnt  <= next_kick_cnt;
            wdog_kick <= next_kick;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_timeout;
        @(posedge clk) disable iff (rst)
        (sv == fos_pkg::SV_WATCH && sv_cnt == CW'(1) && !reacted && !(|new_fault) && clk_en)
            |=> sup_reset_req;
    endproperty
    a_timeout: assert property (p_timeout) else $error("no reset after timeout");

    property p_start;
        @(posedge clk) disable iff (rst)
        (sv == fos_pkg::SV_IDLE && |new_fault && clk_en) |=> sv == fos_pkg::SV_WATCH;
    endproperty
    a_start: assert property (p_start) else $error("watch not started");

    property p_cancel;
        @(posedge clk) disable iff (rst)
        (sv == fos_pkg::SV_WATCH && reacted && !(|new_fault) && clk_en)
            |=> sv == fos_pkg::SV_IDLE && !$rose(sup_reset_req);
    endproperty
    a_cancel: assert property (p_cancel) else $error("watch not cancelled");

    property p_restart;
        @(posedge clk) disable iff (rst)
        (sv == fos_pkg::SV_WATCH && |new_fault && clk_en) |=> sv_cnt == CW'(REACT_CYCLES);
    endproperty
    a_restart: assert property (p_restart) else $error("interval not restarted");

    property p_sticky;
        @(posedge clk) disable iff (rst) sup_reset_req |=> sup_reset_req;
    endproperty
    a_sticky: assert property (p_sticky) else $error("supervisor reset dropped");

    property p_pin;
        @(posedge clk) disable iff (rst) (want_pin && clk_en) |=> fault_indication_pins == 2'h1;
    endproperty
    a_pin: assert property (p_pin) else $error("fault pin not driven");

    property p_hold;
        @(posedge clk) disable iff (rst)
        (hold_cnt != '0 && clk_en) |=> fault_indication_pins[0];
    endproperty
    a_hold: assert property (p_hold) else $error("fault pin released early");

    property p_watch;
        @(posedge clk) disable iff (rst)
        (sv == fos_pkg::SV_WATCH && (fault_irq || fault_reset_req) && !(|new_fault) && clk_en)
            |=> sv != fos_pkg::SV_FAIL;
    endproperty
    a_watch: assert property (p_watch) else $error("reaction ignored");

    property p_kick;
        @(posedge clk) disable iff (rst) (kick_cnt == '0 && clk_en) |=> $changed(wdog_kick);
    endproperty
    a_kick: assert property (p_kick) else $error("watchdog not serviced");

    c_fail:  cover property (@(posedge clk) $rose(sup_reset_req));
    c_react: cover property (@(posedge clk) sv == fos_pkg::SV_WATCH ##1 sv == fos_pkg::SV_IDLE);
    c_kick:  cover property (@(posedge clk) $rose(wdog_kick));
endmodule

// >>> sim/fos_ext_monitor.sv
// Purpose: behavioural external safety monitor on the fault pins
// Assumes: shares the chip clock; trigger is a toggling pin
// Notes:   failure is sticky until rst
`timescale 1ns/1ps
module fos_ext_monitor #(
    parameter int TMO = 24
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // chip side
    input  wire logic [1:0] pins,
    input  wire logic       kick,
    // safety outputs
    output logic            mon_reset,
    output logic            fail_safe
);
    // ****************************************************************
    // timeout and pin watch
    // ****************************************************************
    logic last_kick;
    int   cnt;
    logic fail;
    always_ff @(posedge clk) begin
        if (rst) begin
            last_kick <= 1'b0;
            cnt <= 0;
            fail <= 1'b0;
        end else begin
            last_kick <= kick;
            if (kick != last_kick) begin
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
            if (pins[0] || cnt >= TMO) begin
                fail <= 1'b1;
            end
        end
    end
    assign mon_reset = fail;
    assign fail_safe = fail;
endmodule

// >>> sim/testbench.sv
// Purpose: self-checking bench for fos_supervision
// Assumes: shortened counts and a fixed source table
// Notes:   sources 5 and 6 are enabled with no reaction
`timescale 1ns/1ps
module testbench;
    // ****************************************************************
    // setup
    // ****************************************************************
    localparam int R = 8;
    localparam int H = 16;
    localparam int K = 16;
    localparam int T = 24;
    localparam logic [23:0] MAP = {fos_pkg::REACT_PIN, 3'h6, 3'h5, fos_pkg::REACT_NONE,
        fos_pkg::REACT_PIN, fos_pkg::REACT_RST, fos_pkg::REACT_NMI, fos_pkg::REACT_IRQ};
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       clk_en = 1'b1;
    logic [7:0] fault_in = 8'h00;
    logic       fault_clear = 1'b0;
    logic       fault_irq, fault_nmi, fault_reset_req, sup_reset_req, wdog_kick;
    logic [1:0] fault_indication_pins;
    logic       mon_reset, fail_safe, kick0;
    int         n_fail = 0;
    int         compares = 0;
    int         n;
    wire  [3:0] outs = {fault_indication_pins[0], fault_reset_req, fault_nmi, fault_irq};
    always #25 clk = ~clk;
    fos_supervision #(.NSRC(8), .REACT_CYCLES(R), .HOLD_CYCLES(H), .KICK_CYCLES(K),
        .REACT_MAP(MAP)) u_fos_supervision (.clk(clk), .rst(rst), .clk_en(clk_en),
        .fault_in(fault_in), .fault_clear(fault_clear), .fault_irq(fault_irq),
        .fault_nmi(fault_nmi), .fault_reset_req(fault_reset_req),
        .fault_indication_pins(fault_indication_pins), .sup_reset_req(sup_reset_req),
        .wdog_kick(wdog_kick));
    fos_ext_monitor #(.TMO(T)) u_fos_ext_monitor (.clk(clk), .rst(rst),
        .pins(fault_indication_pins), .kick(wdog_kick), .mon_reset(mon_reset),
        .fail_safe(fail_safe));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        step(2);
    endtask
    task automatic fire(input logic [7:0] m);
        @(posedge clk);
        fault_in <= m;
        @(posedge clk);
        fault_in <= 8'h00;
        #1;
    endtask
    // counts edges until the selected condition holds
    task automatic count_until(input int sel, input int lim);
        n = 0;
        do begin
            step(1);
            n++;
            if (n > lim) begin
                n_fail++;
                print_verdict();
            end
        end while (!(sel == 0 ? sup_reset_req === 1'b1 :
            sel == 1 ? (outs === 4'h0 && fault_indication_pins === 2'h2) :
            sel == 2 ? wdog_kick !== kick0 : mon_reset === 1'b1));
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        chk({sup_reset_req, outs, fault_indication_pins}, 7'h02);
        chk({mon_reset, fail_safe}, 2'h0);
    endtask
    task automatic t_react;
        for (int i = 0; i < 4; i++) begin
            do_reset();
            fire(8'h01 << i);
            step(1);
            chk(outs, 4'h1 << i);
            chk(fault_indication_pins, (i == 3) ? 2'h1 : 2'h2);
            step(R + 2);
            chk(sup_reset_req, 1'b0);
            chk({mon_reset, fail_safe}, (i == 3) ? 2'h3 : 2'h0);
            @(posedge clk);
            fault_clear <= 1'b1;
            @(posedge clk);
            fault_clear <= 1'b0;
            count_until(1, H + 8);
            chk(n > H && n <= H + 3, i == 3);
        end
    endtask
    task automatic t_none;
        do_reset();
        fire(8'h10);
        step(R + 4);
        chk({sup_reset_req, outs}, 5'h00);
    endtask
    task automatic t_cancel;
        do_reset();
        fire(8'h21);
        step(3 * R);
        chk({sup_reset_req, outs}, 5'h01);
    endtask
    task automatic t_timeout;
        do_reset();
        fire(8'h20);
        step(1);
        fire(8'h40);
        count_until(0, 4 * R);
        chk(n >= R - 1 && n <= R + 1, 1'b1);
        step(5);
        chk(sup_reset_req, 1'b1);
    endtask
    task automatic t_kick;
        do_reset();
        kick0 = wdog_kick;
        count_until(2, K + 4);
        kick0 = wdog_kick;
        count_until(2, K + 4);
        chk(n, K);
        chk(mon_reset, 1'b0);
        @(posedge clk);
        clk_en <= 1'b0;
        count_until(3, 2 * T);
        chk(n >= T - 3 && n <= T + 2 && fail_safe === 1'b1, 1'b1);
        @(posedge clk);
        clk_en <= 1'b1;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        step(2);
        t_reset();
        t_react();
        t_none();
        t_cancel();
        t_timeout();
        t_kick();
        print_verdict();
    end
endmodule
